// *** pkg/pin_mux_pkg.sv ***
// package for the pin function multiplexer: register map, field layouts,
// function codes and the structs that carry pin drive and internal sources.
// assumes a 32-bit apb slave with byte addresses equal to four times the index.
package pin_mux_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] PIN3_CFG_INDEX = 8'h51;  // printed index, byte addr = 4x
	localparam logic [7:0] CLKPIN_CFG_INDEX = 8'h52;
	localparam logic [7:0] SERIAL_AMP_CFG_INDEX = 8'h53;
	localparam int ADDR_W = 12;
	localparam logic [7:0] PIN3_CFG_RESET = 8'h01;
	localparam logic [7:0] CLKPIN_CFG_RESET = 8'h03;
	localparam logic [7:0] SERIAL_AMP_CFG_RESET = 8'h00;

	// ----------------------------------------------------------------
	// function select codes, shared by the two configurable pins
	// ----------------------------------------------------------------
	localparam logic [2:0] FN_LOW_OR_CLKIN = 3'h0;  // low level, or clock input on clkpin
	localparam logic [2:0] FN_TXRX_SWITCH = 3'h1;
	localparam logic [2:0] FN_ANTENNA = 3'h2;
	localparam logic [2:0] FN_AMP_CTRL = 3'h3;
	localparam logic [2:0] FN_DATA_IO = 3'h4;
	localparam logic [2:0] FN_DATA_CLOCK = 3'h5;
	localparam logic [2:0] FN_MONITOR = 3'h6;
	localparam logic [2:0] FN_IRQ_NOTIFY = 3'h7;

	// ----------------------------------------------------------------
	// field layouts (bit 7 first)
	// ----------------------------------------------------------------
	typedef struct packed {
		logic out_invert;      // bit 7
		logic open_drain;      // bit 6
		logic forced_value;    // bit 5
		logic force_enable;    // bit 4
		logic reserved3;       // bit 3, stored only
		logic [2:0] function_select;  // bits 2:0
	} pin_cfg_t;

	typedef struct packed {
		logic serial_out_open_drain;  // bit 7
		logic reserved6;
		logic serial_out_pin_select;  // bit 5
		logic serial_in_pin_select;   // bit 4
		logic [1:0] reserved32;
		logic amp_timing_select;      // bit 1
		logic amp_control_enable;     // bit 0
	} serial_amp_cfg_t;

	// a pin as seen by the pad: level and enable
	typedef struct packed {
		logic out;
		logic oe;
	} pin_drive_t;

	// internal radio signals that may be routed to a pin
	typedef struct packed {
		logic txrx_switch_signal;
		logic antenna_select_ctrl;
		logic amp_ctrl;
		logic data_out;
		logic data_oe;
		logic data_clock;
		logic monitor;
		logic interrupt_notify_n;
	} pin_sources_t;

endpackage

// *** core/pin_drive_cell.sv ***
// one output stage: polarity, forced level and open-drain handling for a pin.
// purely combinational; the caller registers the result.
module pin_drive_cell
(
	input wire logic func_value,
	input wire logic func_oe,
	input wire logic out_invert,
	input wire logic open_drain,
	input wire logic force_enable,
	input wire logic forced_value,
	output pin_mux_pkg::pin_drive_t drive
);

	logic level;  // level the pad should show
	logic active;  // the pin is an output at all

	// ----------------------------------------------------------------
	// level and enable
	// ----------------------------------------------------------------
	// forcing bypasses the inversion, so software sees the literal level
	always_comb
	begin
		if (force_enable)
		begin
			level = forced_value;
			active = 1'b1;
		end
		else
		begin
			level = func_value ^ out_invert;
			active = func_oe;
		end
		// open drain only ever pulls low; a high is left to the pull-up
		if (open_drain)
		begin
			drive.out = 1'b0;
			drive.oe = active & ~level;
		end
		else
		begin
			drive.out = level;
			drive.oe = active;
		end
	end

endmodule

// *** core/pin_function_mux_ctrl.sv ***
// pin function multiplexer: apb register file and the routing of internal
// radio signals onto the third general pin, the clock pin and the serial pins.
// assumes pins are synchronous to pclk and the pad resolves level from out/oe.
//
// Notes on behaviour
// - pin3 3-bit code picks its internal source
// - pin3 force enable drives the forced level
// - pin3 forced level ignores the inversion bit
// - pin3 invert bit flips the driven level
// - pin3 open-drain bit makes it pull-low only
// - clkpin code 0 is low-speed clock input
// - clkpin codes 5-7: data clock, monitor, irq
// - clkpin invert bit flips the driven level
// - clkpin open-drain bit makes it pull-low only
// - clkpin forced level ignores the inversion bit
// - clkpin force enable drives the forced level
// - serial out pin push-pull or open-drain
// - serial out: read data, or clock when deselected
// - serial in: write data, or data when deselected
// - amp control follows tx-on or amp-on timing
// - amp control held low when disabled
module pin_function_mux_ctrl
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pin_mux_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// internal radio signals
	input wire logic txrx_switch_signal,
	input wire logic antenna_select_ctrl,
	input wire logic tx_on_timing,
	input wire logic amplifier_on_timing,
	input wire logic radio_data_out,
	input wire logic radio_data_oe,
	input wire logic rx_active,
	input wire logic rx_data_clock,
	input wire logic tx_data_clock,
	input wire logic monitor_signal,
	input wire logic interrupt_notify_n,
	input wire logic serial_read_data,
	input wire logic serial_read_oe,
	output logic radio_data_in,
	output logic low_speed_clock_in,
	output logic serial_write_data,
	// pads
	input wire logic pin3_in,
	output logic pin3_out,
	output logic pin3_oe,
	input wire logic clkpin_in,
	output logic clkpin_out,
	output logic clkpin_oe,
	input wire logic serial_chip_select_n,
	output logic serial_out_pin,
	output logic serial_out_oe,
	input wire logic serial_in_pin,
	output logic serial_in_out,
	output logic serial_in_oe
);

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	// map a byte address to a register slot, 0 = none, 1..3 = registers
	function automatic logic [1:0] reg_slot(input logic [pin_mux_pkg::ADDR_W-1:0] addr);
		logic [1:0] slot;
		slot = 2'h0;
		if (addr[1:0] == 2'h0)
		begin
			if (addr[pin_mux_pkg::ADDR_W-1:2] == 10'(pin_mux_pkg::PIN3_CFG_INDEX))
				slot = 2'h1;
			else if (addr[pin_mux_pkg::ADDR_W-1:2] == 10'(pin_mux_pkg::CLKPIN_CFG_INDEX))
				slot = 2'h2;
			else if (addr[pin_mux_pkg::ADDR_W-1:2] == 10'(pin_mux_pkg::SERIAL_AMP_CFG_INDEX))
				slot = 2'h3;
		end
		return slot;
	endfunction

	// source level for a function code; code 0 is a low level (or input)
	function automatic logic source_level(input logic [2:0] code,
		input pin_mux_pkg::pin_sources_t src);
		logic v;
		v = 1'b0;
		unique case (code)
			pin_mux_pkg::FN_LOW_OR_CLKIN: v = 1'b0;
			pin_mux_pkg::FN_TXRX_SWITCH: v = src.txrx_switch_signal;
			pin_mux_pkg::FN_ANTENNA: v = src.antenna_select_ctrl;
			pin_mux_pkg::FN_AMP_CTRL: v = src.amp_ctrl;
			pin_mux_pkg::FN_DATA_IO: v = src.data_out;
			pin_mux_pkg::FN_DATA_CLOCK: v = src.data_clock;
			pin_mux_pkg::FN_MONITOR: v = src.monitor;
			pin_mux_pkg::FN_IRQ_NOTIFY: v = src.interrupt_notify_n;
		endcase
		return v;
	endfunction

	// output enable for a function code; the data code follows the radio
	function automatic logic source_oe(input logic [2:0] code, input logic code0_is_input,
		input logic data_oe);
		logic e;
		e = 1'b1;
		if (code == pin_mux_pkg::FN_DATA_IO)
			e = data_oe;
		else if (code == pin_mux_pkg::FN_LOW_OR_CLKIN)
			e = ~code0_is_input;
		return e;
	endfunction

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	pin_mux_pkg::pin_cfg_t pin3_cfg_q;  // third general pin
	pin_mux_pkg::pin_cfg_t clkpin_cfg_q;  // low-speed clock pin
	pin_mux_pkg::serial_amp_cfg_t serial_amp_cfg_q;  // serial pins and amplifier
	logic [1:0] slot;  // decoded register slot
	logic write_now;  // write commits at the completing edge
	logic [7:0] read_byte;  // selected register contents

	assign slot = reg_slot(paddr);
	assign write_now = psel & penable & pready & pwrite & (slot != 2'h0) & pstrb[0];

	// ----------------------------------------------------------------
	// apb handshake
	// ----------------------------------------------------------------
	// one wait state keeps pready and prdata straight from flip-flops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready <= 1'b0;
		else if (clk_en)
			pready <= psel & penable & ~pready;
	end

	// unmapped or misaligned addresses answer with an error, no side effect
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pslverr <= 1'b0;
		else if (clk_en)
			pslverr <= psel & penable & ~pready & (slot == 2'h0);
	end

	always_comb
	begin
		unique case (slot)
			2'h1: read_byte = pin3_cfg_q;
			2'h2: read_byte = clkpin_cfg_q;
			2'h3: read_byte = serial_amp_cfg_q;
			default: read_byte = 8'h00;
		endcase
	end

	// read data is loaded with pready and held through the completing edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (clk_en && psel && penable && !pready)
			prdata <= {24'h00_0000, read_byte};
	end

	// ----------------------------------------------------------------
	// configuration storage
	// ----------------------------------------------------------------
	// reserved bits are kept so software reads back what it wrote
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pin3_cfg_q <= pin_mux_pkg::PIN3_CFG_RESET;
		else if (clk_en && write_now && slot == 2'h1)
			pin3_cfg_q <= pwdata[7:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			clkpin_cfg_q <= pin_mux_pkg::CLKPIN_CFG_RESET;
		else if (clk_en && write_now && slot == 2'h2)
			clkpin_cfg_q <= pwdata[7:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			serial_amp_cfg_q <= pin_mux_pkg::SERIAL_AMP_CFG_RESET;
		else if (clk_en && write_now && slot == 2'h3)
			serial_amp_cfg_q <= pwdata[7:0];
	end

	// ----------------------------------------------------------------
	// internal sources
	// ----------------------------------------------------------------
	pin_mux_pkg::pin_sources_t src;  // signals offered to the pins
	logic amp_ctrl;  // external amplifier control
	logic data_clock;  // rx clock while receiving, tx clock otherwise
	logic serial_deselected;  // chip select high: data pins lent to radio

	// disabled amp control is held low whatever the timing choice
	assign amp_ctrl = serial_amp_cfg_q.amp_control_enable &
		(serial_amp_cfg_q.amp_timing_select ? amplifier_on_timing : tx_on_timing);
	assign data_clock = rx_active ? rx_data_clock : tx_data_clock;
	assign serial_deselected = serial_chip_select_n;

	always_comb
	begin
		src.txrx_switch_signal = txrx_switch_signal;
		src.antenna_select_ctrl = antenna_select_ctrl;
		src.amp_ctrl = amp_ctrl;
		src.data_out = radio_data_out;
		src.data_oe = radio_data_oe;
		src.data_clock = data_clock;
		src.monitor = monitor_signal;
		src.interrupt_notify_n = interrupt_notify_n;
	end

	// ----------------------------------------------------------------
	// output stages
	// ----------------------------------------------------------------
	pin_mux_pkg::pin_drive_t pin3_d;
	pin_mux_pkg::pin_drive_t clkpin_d;
	pin_mux_pkg::pin_drive_t sdo_d;
	logic sdo_value;  // read data or data clock
	logic sdo_enable;  // read data only drives while the port reads

	// serial out pin carries the data clock only while deselected
	assign sdo_value = (serial_amp_cfg_q.serial_out_pin_select && serial_deselected) ?
		data_clock : serial_read_data;
	assign sdo_enable = (serial_amp_cfg_q.serial_out_pin_select && serial_deselected) ?
		1'b1 : serial_read_oe;

	// reserved bit 3 is not wired to the stage
	pin_drive_cell u_pin3_stage
	(
		.func_value(source_level(pin3_cfg_q.function_select, src)),
		.func_oe(source_oe(pin3_cfg_q.function_select, 1'b0, radio_data_oe)),
		.out_invert(pin3_cfg_q.out_invert),
		.open_drain(pin3_cfg_q.open_drain),
		.force_enable(pin3_cfg_q.force_enable),
		.forced_value(pin3_cfg_q.forced_value),
		.drive(pin3_d)
	);

	// code 0 turns the clock pin into an input
	pin_drive_cell u_clkpin_stage
	(
		.func_value(source_level(clkpin_cfg_q.function_select, src)),
		.func_oe(source_oe(clkpin_cfg_q.function_select, 1'b1, radio_data_oe)),
		.out_invert(clkpin_cfg_q.out_invert),
		.open_drain(clkpin_cfg_q.open_drain),
		.force_enable(clkpin_cfg_q.force_enable),
		.forced_value(clkpin_cfg_q.forced_value),
		.drive(clkpin_d)
	);

	// the serial out pin has no inversion or forcing
	pin_drive_cell u_sdo_stage
	(
		.func_value(sdo_value),
		.func_oe(sdo_enable),
		.out_invert(1'b0),
		.open_drain(serial_amp_cfg_q.serial_out_open_drain),
		.force_enable(1'b0),
		.forced_value(1'b0),
		.drive(sdo_d)
	);

	// ----------------------------------------------------------------
	// pad registers
	// ----------------------------------------------------------------
	// registering costs one cycle of delay but keeps pads glitch free
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin3_out <= 1'b0;
			pin3_oe <= 1'b0;
			clkpin_out <= 1'b0;
			clkpin_oe <= 1'b0;
			serial_out_pin <= 1'b0;
			serial_out_oe <= 1'b0;
		end
		else if (clk_en)
		begin
			pin3_out <= pin3_d.out;
			pin3_oe <= pin3_d.oe;
			clkpin_out <= clkpin_d.out;
			clkpin_oe <= clkpin_d.oe;
			serial_out_pin <= sdo_d.out;
			serial_out_oe <= sdo_d.oe;
		end
	end

	// serial in pin doubles as the radio data pin while deselected
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			serial_in_out <= 1'b0;
			serial_in_oe <= 1'b0;
		end
		else if (clk_en)
		begin
			serial_in_out <= radio_data_out;
			serial_in_oe <= serial_amp_cfg_q.serial_in_pin_select & serial_deselected &
				radio_data_oe;
		end
	end

	// ----------------------------------------------------------------
	// inputs gathered from the pads
	// ----------------------------------------------------------------
	// when several pins carry data, pin3 wins, then clkpin, then serial in
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			radio_data_in <= 1'b0;
		else if (clk_en)
		begin
			if (pin3_cfg_q.function_select == pin_mux_pkg::FN_DATA_IO)
				radio_data_in <= pin3_in;
			else if (clkpin_cfg_q.function_select == pin_mux_pkg::FN_DATA_IO)
				radio_data_in <= clkpin_in;
			else if (serial_amp_cfg_q.serial_in_pin_select && serial_deselected)
				radio_data_in <= serial_in_pin;
			else
				radio_data_in <= 1'b0;
		end
	end

	// low-speed clock only passes in input mode, otherwise held low
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			low_speed_clock_in <= 1'b0;
		else if (clk_en)
			low_speed_clock_in <= (clkpin_cfg_q.function_select ==
				pin_mux_pkg::FN_LOW_OR_CLKIN) & clkpin_in;
	end

	// write data reaches the serial port only while it owns the pin
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			serial_write_data <= 1'b0;
		else if (clk_en)
			serial_write_data <= (serial_amp_cfg_q.serial_in_pin_select && serial_deselected) ?
				1'b0 : serial_in_pin;
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_pin3_low_code;
		@(posedge pclk) disable iff (!presetn)
		clk_en && pin3_cfg_q[7:0] == 8'h00 |=> pin3_out == 1'b0 && pin3_oe;
	endproperty
	a_pin3_low_code: assert property (p_pin3_low_code) else $error("pin3 code 0 not low");

	property p_pin3_force;
		@(posedge pclk) disable iff (!presetn)
		clk_en && pin3_cfg_q.force_enable && !pin3_cfg_q.open_drain |=>
			pin3_oe && pin3_out == $past(pin3_cfg_q.forced_value);
	endproperty
	a_pin3_force: assert property (p_pin3_force) else $error("pin3 forced level wrong");

	property p_pin3_invert;
		@(posedge pclk) disable iff (!presetn)
		clk_en && pin3_cfg_q[6:0] == 7'h01 |=>
			pin3_out == ($past(txrx_switch_signal) ^ $past(pin3_cfg_q.out_invert));
	endproperty
	a_pin3_invert: assert property (p_pin3_invert) else $error("pin3 polarity wrong");

	property p_pin3_open_drain;
		@(posedge pclk) disable iff (!presetn)
		clk_en && pin3_cfg_q.open_drain |=> pin3_out == 1'b0;
	endproperty
	a_pin3_open_drain: assert property (p_pin3_open_drain) else $error("pin3 drove high in od");

	property p_clkpin_input;
		@(posedge pclk) disable iff (!presetn)
		clk_en && clkpin_cfg_q.function_select == 3'h0 && !clkpin_cfg_q.force_enable
			|=> !clkpin_oe && low_speed_clock_in == $past(clkpin_in);
	endproperty
	a_clkpin_input: assert property (p_clkpin_input) else $error("clkpin not an input");

	property p_clkpin_data_clock;
		@(posedge pclk) disable iff (!presetn)
		clk_en && clkpin_cfg_q[6:0] == 7'h05 && rx_active |=>
			clkpin_out == ($past(rx_data_clock) ^ $past(clkpin_cfg_q.out_invert));
	endproperty
	a_clkpin_data_clock: assert property (p_clkpin_data_clock) else $error("rx clock missing");

	property p_clkpin_force;
		@(posedge pclk) disable iff (!presetn)
		clk_en && clkpin_cfg_q.force_enable && clkpin_cfg_q.out_invert &&
			!clkpin_cfg_q.open_drain |=> clkpin_out == $past(clkpin_cfg_q.forced_value);
	endproperty
	a_clkpin_force: assert property (p_clkpin_force) else $error("clkpin force inverted");

	property p_sdo_clock_mode;
		@(posedge pclk) disable iff (!presetn)
		clk_en && serial_amp_cfg_q[7:5] == 3'h1 && serial_chip_select_n |=>
			serial_out_oe && serial_out_pin == $past(data_clock);
	endproperty
	a_sdo_clock_mode: assert property (p_sdo_clock_mode) else $error("sdo clock mode wrong");

	property p_amp_disabled;
		@(posedge pclk) disable iff (!presetn)
		clk_en && !serial_amp_cfg_q.amp_control_enable && pin3_cfg_q[7:0] == 8'h03
			|=> pin3_out == 1'b0;
	endproperty
	a_amp_disabled: assert property (p_amp_disabled) else $error("amp control not held low");

	property p_write_effect;
		@(posedge pclk) disable iff (!presetn)
		clk_en && write_now && slot == 2'h3 |=> serial_amp_cfg_q == $past(pwdata[7:0]);
	endproperty
	a_write_effect: assert property (p_write_effect) else $error("write not stored");

endmodule

// *** sim/pad_partner.sv ***
// far side of the pads: a pull-up on pin3, a slow clock source and the host's serial line.
// assumes the pad drive pairs out/oe from the mux, oe high while the device drives.
module pad_partner
#(
	parameter int LS_HALF = 40  // half period of the slow clock, in pclk cycles
)
(
	input wire logic pclk,
	input wire logic pin3_out,
	input wire logic pin3_oe,
	input wire logic clkpin_out,
	input wire logic clkpin_oe,
	input wire logic serial_in_out,
	input wire logic serial_in_oe,
	input wire logic host_sdi,
	output logic pin3_in,
	output logic clkpin_in,
	output logic serial_in_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// slow clock source, shortened so the run stays brief
	// ----------------------------------------------------------------
	logic ls_q = 1'b0;  // slow clock level
	int cnt = 0;  // half period counter
	// toggles free-running; the source does not care who listens
	always @(posedge pclk)
	begin
		if (cnt == LS_HALF - 1)
		begin
			cnt <= 0;
			ls_q <= ~ls_q;
		end
		else
			cnt <= cnt + 1;
	end
	// released pin3 floats up to the pull-up; released clkpin and serial in lines take the slow clock and host line
	assign pin3_in = pin3_oe ? pin3_out : 1'b1;
	assign clkpin_in = clkpin_oe ? clkpin_out : ls_q;
	assign serial_in_pin = serial_in_oe ? serial_in_out : host_sdi;
endmodule

// *** sim/tb_pin_function_mux_ctrl.sv ***
// self-checking bench for the pin function multiplexer.
// assumes apb with one wait state or more; pads registered one cycle.
module tb_pin_function_mux_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// stimulus and observation
	// ----------------------------------------------------------------
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr;
	logic [12:0] src = 13'h0000;  // internal radio sources, see fsel
	logic cs_n = 1'b1, host_sdi = 1'b0;
	logic clk_en = 1'b1;  // freezes the design while low
	logic radio_data_in, low_speed_clock_in, serial_write_data;
	logic pin3_in, pin3_out, pin3_oe, clkpin_in, clkpin_out, clkpin_oe;
	logic serial_out_pin, serial_out_oe, serial_in_pin, serial_in_out, serial_in_oe;
	int failures = 0;
	int check_count = 0;
	initial forever #2.5 pclk = ~pclk;
	pin_function_mux_ctrl DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.txrx_switch_signal(src[0]), .antenna_select_ctrl(src[1]), .tx_on_timing(src[2]),
		.amplifier_on_timing(src[3]), .radio_data_out(src[4]), .radio_data_oe(src[5]),
		.rx_active(src[6]), .rx_data_clock(src[7]), .tx_data_clock(src[8]),
		.monitor_signal(src[9]), .interrupt_notify_n(src[10]), .serial_read_data(src[11]),
		.serial_read_oe(src[12]), .radio_data_in(radio_data_in),
		.low_speed_clock_in(low_speed_clock_in), .serial_write_data(serial_write_data),
		.pin3_in(pin3_in), .pin3_out(pin3_out), .pin3_oe(pin3_oe), .clkpin_in(clkpin_in),
		.clkpin_out(clkpin_out), .clkpin_oe(clkpin_oe), .serial_chip_select_n(cs_n),
		.serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
		.serial_in_pin(serial_in_pin), .serial_in_out(serial_in_out),
		.serial_in_oe(serial_in_oe));
	pad_partner partner (.pclk(pclk), .pin3_out(pin3_out), .pin3_oe(pin3_oe),
		.clkpin_out(clkpin_out), .clkpin_oe(clkpin_oe), .serial_in_out(serial_in_out),
		.serial_in_oe(serial_in_oe), .host_sdi(host_sdi), .pin3_in(pin3_in),
		.clkpin_in(clkpin_in), .serial_in_pin(serial_in_pin));
	// ----------------------------------------------------------------
	// verdict, compares and the bus master
	// ----------------------------------------------------------------
	task automatic print_verdict();
		if (failures == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR t=%0t reg got %h exp %h", $time, got, exp);
		end
	endtask
	// pad compare as {oe, driven level}; a released push-pull pad's level is moot
	task automatic chk_pad(input logic [1:0] got, input logic [1:0] exp);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR t=%0t pad got %h exp %h", $time, got, exp);
		end
	endtask
	// one apb transfer; holds the request until pready is seen at an edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			failures++;
			print_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// ----------------------------------------------------------------
	// expectation functions
	// ----------------------------------------------------------------
	// forcing wins over inversion; open drain only ever pulls low
	function automatic logic [1:0] pad(input logic [7:0] c, input logic [1:0] f);
		logic l;
		logic act;
		l = c[4] ? c[5] : (f[0] ^ c[7]);
		act = c[4] | f[1];
		return c[6] ? {act & ~l, 1'b0} : {act, act & l};
	endfunction
	// selected function as {oe, level}; code 0 is low on pin3, input on clkpin
	function automatic logic [1:0] fsel(input logic [2:0] code, input logic clk,
		input logic [7:0] sa);
		logic radio_data_clock;
		logic amp;
		radio_data_clock = src[6] ? src[7] : src[8];
		amp = sa[0] & (sa[1] ? src[3] : src[2]);
		case (code)
			3'h0: return clk ? 2'b00 : 2'b10;
			3'h1: return {1'b1, src[0]};
			3'h2: return {1'b1, src[1]};
			3'h3: return {1'b1, amp};
			3'h4: return {src[5], src[4]};
			3'h5: return {1'b1, radio_data_clock};
			3'h6: return {1'b1, src[9]};
			default: return {1'b1, src[10]};
		endcase
	endfunction
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		logic [7:0] cfg [3];
		logic [11:0] adr [3];
		logic [31:0] rd;
		logic err;
		logic ls;
		logic [1:0] so;
		logic [1:0] p3;
		logic [1:0] pc;
		logic [1:0] rx;
		logic lsv;
		adr = '{12'h144, 12'h148, 12'h14c};
		void'($urandom(15322));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		cfg = '{8'h01, 8'h03, 8'h00};
		for (int r = 0; r < 3; r++)
		begin
			apb(1'b0, adr[r], 32'h0, rd, err);
			chk_reg(rd, {24'h0, cfg[r]});
			chk_reg({31'h0, err}, 32'h0000_0000);
		end
		// unmapped and misaligned places answer with an error and no data
		apb(1'b0, 12'h150, 32'h0, rd, err);
		chk_reg({rd[31:1], err}, 32'h0000_0001);
		apb(1'b1, 12'h145, 32'h0000_00ff, rd, err);
		chk_reg({31'h0, err}, 32'h0000_0001);
		// the refused write must leave pin3 at its reset value
		apb(1'b0, adr[0], 32'h0, rd, err);
		chk_reg(rd, {24'h0, cfg[0]});
		for (int i = 0; i < 300; i++)
		begin
			for (int r = 0; r < 3; r++)
				cfg[r] = 8'($urandom);
			if (i < 8)
			begin
				cfg[0][4] = 1'b0;
				cfg[1][4] = 1'b0;
				cfg[0][2:0] = 3'(i);
				cfg[1][2:0] = 3'(i);
			end
			for (int r = 0; r < 3; r++)
				apb(1'b1, adr[r], {24'($urandom), cfg[r]}, rd, err);
			for (int r = 0; r < 3; r++)
			begin
				apb(1'b0, adr[r], 32'h0, rd, err);
				chk_reg(rd, {24'h0, cfg[r]});
			end
			@(posedge pclk);
			src <= 13'($urandom);
			cs_n <= 1'($urandom);
			host_sdi <= 1'($urandom);
			repeat (2) @(posedge pclk);
			// slow clock level as the design samples it at this edge
			lsv = partner.ls_q;
			@(negedge pclk);
			p3 = pad(cfg[0], fsel(cfg[0][2:0], 1'b0, cfg[2]));
			pc = pad(cfg[1], fsel(cfg[1][2:0], 1'b1, cfg[2]));
			chk_pad({pin3_oe, pin3_oe & pin3_out}, p3);
			chk_pad({clkpin_oe, clkpin_oe & clkpin_out}, pc);
			// serial out: clock while deselected in shared mode, else read data
			ls = (cfg[2][5] & cs_n) ? (src[6] ? src[7] : src[8]) : src[11];
			so = {(cfg[2][5] & cs_n) | src[12], ls};
			chk_pad({serial_out_oe, serial_out_oe & serial_out_pin},
				cfg[2][7] ? {so[1] & ~ls, 1'b0} : {so[1], so[1] & ls});
			if (cfg[2][4] & cs_n)
				chk_pad({serial_in_oe, serial_write_data},
					{src[5], 1'b0});
			else
				chk_pad({serial_in_oe, serial_write_data}, {1'b0, host_sdi});
			// data in: pin3 wins, then clkpin, then the lent serial in pin
			if (cfg[0][2:0] == 3'h4)
				rx[1] = p3[1] ? p3[0] : 1'b1;
			else if (cfg[1][2:0] == 3'h4)
				rx[1] = pc[1] ? pc[0] : lsv;
			else if (cfg[2][4] & cs_n)
				rx[1] = src[5] ? src[4] : host_sdi;
			else
				rx[1] = 1'b0;
			rx[0] = (cfg[1][2:0] == 3'h0) & (pc[1] ? pc[0] : lsv);
			chk_pad({radio_data_in, low_speed_clock_in}, rx);
			chk_pad({serial_in_out, 1'b0}, {src[4], 1'b0});
		end
		// clock enable low freezes every flop; only the pin3 pad pair is checked to hold
		so = {pin3_oe, pin3_out};
		@(posedge pclk);
		clk_en <= 1'b0;
		src <= ~src;
		repeat (3) @(posedge pclk);
		@(negedge pclk);
		chk_pad({pin3_oe, pin3_out}, so);
		print_verdict();
	end
	// a hung transfer or pad check ends the run long after the tests should have
	initial
	begin
		#400000;
		failures++;
		print_verdict();
	end
endmodule
